// ===== src/dcad_consts.svh
// Constants of the daisy chain addressing and sequencing block
`ifndef DCAD_CONSTS_SVH
`define DCAD_CONSTS_SVH

// ----------------------------------------------------------------------
// Setup word layout
// ----------------------------------------------------------------------
`define DCAD_F_RATE_MSB   11
`define DCAD_F_RATE_LSB   10
`define DCAD_F_ROLE_MSB   9
`define DCAD_F_ROLE_LSB   8
`define DCAD_F_SIZE_MSB   7
`define DCAD_F_SIZE_LSB   4
`define DCAD_F_POS_MSB    3
`define DCAD_F_POS_LSB    0
`define DCAD_SETUP_RESET  12'h000

// ----------------------------------------------------------------------
// Addresses, frame sizes, response lengths
// ----------------------------------------------------------------------
`define DCAD_ADDR_IDENT   4'h0
`define DCAD_ADDR_ALL     4'hf
`define DCAD_RD_BITS      6'h14
`define DCAD_WR_BITS      6'h1c
`define DCAD_RD_LAST      6'h17
`define DCAD_WR_LAST      6'h1f
`define DCAD_LEN_SHORT    6'h04
`define DCAD_LEN_CELLS    6'h28
`define DCAD_LEN_TEMPS    6'h16
`define DCAD_LEN_SETUP    6'h2b

// ----------------------------------------------------------------------
// Timing, in link periods and in sys clock cycles
// ----------------------------------------------------------------------
`define DCAD_SCAN_BASE    8'h1c
`define DCAD_MRSP_BASE    8'h2a
`define DCAD_MRSP_TAIL    8'h08
`define DCAD_SRSP_BASE    8'h32
`define DCAD_RD_FRAME     8'h18
`define DCAD_BYTE_TICKS   8'h09
`define DCAD_CLK_NS       5
`define DCAD_RATE0_NS     2000
`define DCAD_RATE1_NS     4000
`define DCAD_RATE2_NS     8000
`define DCAD_RATE3_NS     16000
`define DCAD_SCAN_SYNC_NS 2000
`define DCAD_RSP_SYNC_NS  4000
`define DCAD_RATE0_CYC    (`DCAD_RATE0_NS / `DCAD_CLK_NS)
`define DCAD_RATE1_CYC    (`DCAD_RATE1_NS / `DCAD_CLK_NS)
`define DCAD_RATE2_CYC    (`DCAD_RATE2_NS / `DCAD_CLK_NS)
`define DCAD_RATE3_CYC    (`DCAD_RATE3_NS / `DCAD_CLK_NS)
`define DCAD_SCAN_CYC     ((`DCAD_SCAN_SYNC_NS + `DCAD_CLK_NS - 1) / `DCAD_CLK_NS)
`define DCAD_RSP_CYC      ((`DCAD_RSP_SYNC_NS + `DCAD_CLK_NS - 1) / `DCAD_CLK_NS)

`endif

// ===== src/dcad_pkg.sv
// Types shared by the daisy chain addressing block
package dcad_pkg;

  typedef enum logic [1:0] {
    ROLE_ALONE  = 2'b00,
    ROLE_MASTER = 2'b01,
    ROLE_MIDDLE = 2'b10,
    ROLE_TOP    = 2'b11
  } dcad_role_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_TICKS  = 3'b001,
    ST_SYNC   = 3'b010,
    ST_STROBE = 3'b011,
    ST_SHIFT  = 3'b100,
    ST_LINK   = 3'b101
  } dcad_state_t;

  typedef enum logic [3:0] {
    CMD_SCAN    = 4'h1,
    CMD_MEASURE = 4'h2,
    CMD_REG_RD  = 4'h3,
    CMD_CELLS   = 4'h4,
    CMD_TEMPS   = 4'h5,
    CMD_FAULTS  = 4'h6,
    CMD_SETUP   = 4'h7,
    CMD_ACK     = 4'h8
  } dcad_cmd_t;

  // Byte handed from the sys domain to the link transmitter
  typedef struct packed {
    logic [3:0] extra;
    logic       append;
    logic [7:0] data;
  } dcad_xfer_t;

  // Frame, left aligned in 32 bits
  typedef struct packed {
    logic [3:0]  addr;
    logic        rw;
    logic [2:0]  rsvd;
    logic [3:0]  cmd;
    logic [3:0]  arg;
    logic [15:0] tail;
  } dcad_frame_t;

endpackage

// ===== src/dcad_crc4.sv
// Bit-serial 4-bit CRC over the leading bits of a 32-bit word
`timescale 1ns/1ps
`default_nettype none
module dcad_crc4 (
  input  wire logic [31:0] bits_in,
  input  wire logic [5:0]  nbits_in,
  output logic      [3:0]  crc_out
);
  always_comb begin
    logic [3:0] c;
    logic       fb;
    c  = 4'h0;
    fb = 1'b0;
    for (int i = 0; i < 32; i++) begin
      if (6'(i) < nbits_in) begin
        fb = bits_in[31 - i] ^ c[3];
        c  = {c[2], c[1], c[0] ^ c[3], fb};
      end
    end
    crc_out = c;
  end
endmodule
`default_nettype wire

// ===== src/dcad_top.sv
// Daisy chain addressing, command relay and response sequencing
`timescale 1ns/1ps
`default_nettype none
`include "dcad_consts.svh"
module dcad_top
  import dcad_pkg::*;
(
  // Clocks and reset
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        daisy_clk_in,
  // Host SPI
  input  wire logic        spi_sclk_in,
  input  wire logic        spi_cs_n_in,
  input  wire logic        spi_mosi_in,
  output logic             spi_miso_out,
  output logic             data_ready_n_out,
  // Strap pins
  input  wire logic [1:0]  link_rate_strap_in,
  input  wire logic [1:0]  link_role_strap_in,
  // Daisy link, on daisy_clk_in
  input  wire logic        daisy_rx_data_in,
  input  wire logic        daisy_rx_frame_in,
  output logic             daisy_tx_data_out,
  output logic             daisy_tx_frame_out,
  // Measurement side
  input  wire logic        meas_update_in,
  input  wire logic [7:0]  rsp_byte_in,
  output logic      [5:0]  rsp_idx_out,
  output logic             scan_start_out,
  output logic             meas_busy_out,
  output logic             results_ready_out,
  output logic      [11:0] link_setup_status_out
);

  // --------------------------------------------------------------------
  // Pin synchronisers, sys domain
  // --------------------------------------------------------------------
  logic [6:0] pin_s1_r, pin_s2_r;
  logic       sclk_d_r, cs_d_r;
  logic [1:0] dz_s1_r, dz_s2_r, dz_s3_r;
  logic       dz_st_tgl_r, dz_end_tgl_r;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      // Clock bit starts at the mode 0 idle level: no false edge
      pin_s1_r <= 7'h02;
      pin_s2_r <= 7'h02;
      sclk_d_r <= 1'b0;
      cs_d_r   <= 1'b1;
      dz_s1_r  <= 2'h0;
      dz_s2_r  <= 2'h0;
      dz_s3_r  <= 2'h0;
    end else begin
      pin_s1_r <= {link_role_strap_in, link_rate_strap_in, spi_mosi_in,
                   spi_cs_n_in, spi_sclk_in};
      pin_s2_r <= pin_s1_r;
      sclk_d_r <= pin_s2_r[0];
      cs_d_r   <= pin_s2_r[1];
      dz_s1_r  <= {dz_end_tgl_r, dz_st_tgl_r};
      dz_s2_r  <= dz_s1_r;
      dz_s3_r  <= dz_s2_r;
    end
  end

  dcad_role_t role;
  logic       sclk_rise, sclk_fall, cs_low, cs_rise, is_master, host_side;
  logic       dz_start, dz_end;
  assign role      = dcad_role_t'(pin_s2_r[6:5]);
  assign sclk_rise = pin_s2_r[0] & ~sclk_d_r;
  assign sclk_fall = ~pin_s2_r[0] & sclk_d_r;
  assign cs_low    = ~pin_s2_r[1];
  assign cs_rise   = pin_s2_r[1] & ~cs_d_r;
  assign is_master = (role == ROLE_MASTER);
  assign host_side = is_master | (role == ROLE_ALONE);
  assign dz_start  = dz_s2_r[0] ^ dz_s3_r[0];
  assign dz_end    = dz_s2_r[1] ^ dz_s3_r[1];

  // --------------------------------------------------------------------
  // Sys domain state
  // --------------------------------------------------------------------
  dcad_state_t st_r, st_nxt;
  dcad_xfer_t  fwd_w_r, fwd_w_nxt;
  logic        fwd_tgl_r, fwd_tgl_nxt;
  logic [7:0]  spi_sh_r, spi_sh_nxt;
  logic [2:0]  spi_bit_r, spi_bit_nxt, spi_byte_r, spi_byte_nxt;
  logic [31:0] spi_w_r, spi_w_nxt;
  logic        spi_rw_r, spi_rw_nxt, spi_ev_r, spi_ev_nxt;
  logic [3:0]  pos_r, pos_nxt, size_r, size_nxt, cmd_r, cmd_nxt;
  logic [11:0] pre_r, pre_nxt, cnt_r, cnt_nxt, status_r, status_nxt;
  logic [7:0]  ticks_r, ticks_nxt, tgt_r, tgt_nxt, rsp_sh_r, rsp_sh_nxt;
  logic [5:0]  len_r, len_nxt, idx_r, idx_nxt;
  logic        act_scan_r, act_scan_nxt, pend_r, pend_nxt;
  logic        scan_r, scan_nxt, busy_r, busy_nxt, ready_r, ready_nxt;
  logic        dr_n_r, dr_n_nxt, miso_r, miso_nxt;
  logic [31:0] dz_word_r;
  logic        dz_len4_r;

  // Incoming frame, from SPI on host side, else from the link
  dcad_frame_t ev_f;
  logic [31:0] ev_raw;
  logic        ev, ev_len4, ev_ok, addr_hit;
  logic [3:0]  ev_crc, rd_crc, ev_got;
  logic [11:0] period;
  logic [7:0]  cur_byte;
  logic [5:0]  rsp_len;

  assign ev      = host_side ? spi_ev_r : dz_end;
  assign ev_len4 = host_side ? spi_rw_r : dz_len4_r;
  assign ev_raw  = host_side ? spi_w_r : dz_word_r;
  assign ev_f    = ev_len4 ? ev_raw : {ev_raw[23:0], 8'h00};
  assign ev_got  = ev_len4 ? ev_raw[3:0] : ev_f.tail[11:8];
  assign ev_ok   = (ev_crc == ev_got);
  // Broadcast and identify reach every device
  assign addr_hit = (ev_f.addr == pos_r) || (ev_f.addr == `DCAD_ADDR_ALL) ||
                    (ev_f.addr == `DCAD_ADDR_IDENT);

  dcad_crc4 u_crc_rx (
    .bits_in  (ev_f),
    .nbits_in (ev_len4 ? `DCAD_WR_BITS : `DCAD_RD_BITS),
    .crc_out  (ev_crc)
  );

  dcad_crc4 u_crc_tx (
    .bits_in  ({pos_r, 4'h0, 4'h0, status_r, 8'h00}),
    .nbits_in (`DCAD_WR_BITS),
    .crc_out  (rd_crc)
  );

  always_comb begin
    case (pin_s2_r[4:3])
      2'h0:    period = 12'(`DCAD_RATE0_CYC);
      2'h1:    period = 12'(`DCAD_RATE1_CYC);
      2'h2:    period = 12'(`DCAD_RATE2_CYC);
      default: period = 12'(`DCAD_RATE3_CYC);
    endcase
    case (ev_f.cmd)
      CMD_CELLS:             rsp_len = `DCAD_LEN_CELLS;
      CMD_TEMPS, CMD_FAULTS: rsp_len = `DCAD_LEN_TEMPS;
      CMD_SETUP:             rsp_len = `DCAD_LEN_SETUP;
      default:               rsp_len = `DCAD_LEN_SHORT;
    endcase
    if (cmd_r != CMD_REG_RD) begin
      cur_byte = rsp_byte_in;
    end else if (idx_r == 6'h00) begin
      cur_byte = {pos_r, 4'h0};
    end else if (idx_r == 6'h01) begin
      cur_byte = {4'h0, status_r[11:8]};
    end else if (idx_r == 6'h02) begin
      cur_byte = status_r[7:0];
    end else begin
      cur_byte = {4'h0, rd_crc};
    end
  end

  always_comb begin
    st_nxt       = st_r;
    fwd_w_nxt    = fwd_w_r;
    fwd_tgl_nxt  = fwd_tgl_r;
    spi_sh_nxt   = spi_sh_r;
    spi_bit_nxt  = spi_bit_r;
    spi_byte_nxt = spi_byte_r;
    spi_w_nxt    = spi_w_r;
    spi_rw_nxt   = spi_rw_r;
    spi_ev_nxt   = 1'b0;
    pos_nxt      = pos_r;
    size_nxt     = size_r;
    cmd_nxt      = cmd_r;
    pre_nxt      = pre_r + 12'h001;
    ticks_nxt    = ticks_r;
    cnt_nxt      = cnt_r;
    tgt_nxt      = tgt_r;
    rsp_sh_nxt   = rsp_sh_r;
    len_nxt      = len_r;
    idx_nxt      = idx_r;
    act_scan_nxt = act_scan_r;
    pend_nxt     = pend_r;
    scan_nxt     = 1'b0;
    dr_n_nxt     = dr_n_r;
    miso_nxt     = miso_r;
    // Read-only word; count and position change only at identify
    status_nxt = {pin_s2_r[4:3], pin_s2_r[6:5], size_r, pos_r};
    // Link period time base
    if (pre_r >= period - 12'h001) begin
      pre_nxt = 12'h000;
      if (ticks_r != 8'hff) ticks_nxt = ticks_r + 8'h01;
    end
    if (dz_start || spi_ev_r) begin
      pre_nxt   = 12'h000;
      ticks_nxt = 8'h00;
    end
    // SPI receive, ignored while a response byte is shifted out
    if (cs_rise) begin
      spi_bit_nxt  = 3'h0;
      spi_byte_nxt = 3'h0;
    end else if (cs_low && sclk_rise && st_r != ST_SHIFT) begin
      spi_sh_nxt  = {spi_sh_r[6:0], pin_s2_r[2]};
      spi_bit_nxt = spi_bit_r + 3'h1;
      if (spi_bit_r == 3'h7) begin
        spi_w_nxt    = {spi_w_r[23:0], spi_sh_nxt};
        spi_byte_nxt = spi_byte_r + 3'h1;
        if (spi_byte_r == 3'h0) spi_rw_nxt = spi_sh_nxt[3];
        if (spi_byte_nxt == (spi_rw_nxt ? 3'h4 : 3'h3)) begin
          spi_ev_nxt   = 1'b1;
          spi_byte_nxt = 3'h0;
        end
        // Each byte leaves as soon as it is complete
        if (is_master) begin
          fwd_w_nxt.data   = spi_sh_nxt;
          fwd_w_nxt.append = spi_ev_nxt;
          // Extra clocks only close a frame, never sit between bytes
          fwd_w_nxt.extra  = (spi_ev_nxt && size_r > 4'h1) ?
                             size_r - 4'h2 : 4'h0;
          fwd_tgl_nxt      = ~fwd_tgl_r;
        end
      end
    end
    // Host side scan starts on the next falling SPI clock
    if (pend_r && sclk_fall) begin
      pend_nxt = 1'b0;
      scan_nxt = 1'b1;
    end
    case (st_r)
      ST_IDLE: begin
        if (ev && ev_ok) begin
          cmd_nxt = ev_f.cmd;
          if (ev_f.addr == `DCAD_ADDR_IDENT) begin
            pos_nxt  = ev_f.arg;
            size_nxt = ev_f.tail[15:12];
          end else if (!ev_f.rw && (addr_hit || is_master)) begin
            if (ev_f.cmd == CMD_SCAN || ev_f.cmd == CMD_MEASURE) begin
              if (!addr_hit) begin
                pend_nxt = 1'b0;
              end else if (host_side) begin
                pend_nxt = 1'b1;
              end else begin
                tgt_nxt = `DCAD_SCAN_BASE + {4'h0, pos_r} - 8'h02;
                act_scan_nxt = 1'b1;
                st_nxt       = ST_TICKS;
              end
            end else if (ev_f.cmd >= CMD_REG_RD && ev_f.cmd <= CMD_ACK) begin
              len_nxt      = rsp_len;
              act_scan_nxt = 1'b0;
              st_nxt       = ST_TICKS;
              if (is_master) begin
                tgt_nxt = `DCAD_MRSP_BASE + {4'h0, size_r} - 8'h02 +
                          `DCAD_MRSP_TAIL;
              end else if (host_side) begin
                tgt_nxt = 8'h00;
              end else begin
                tgt_nxt = `DCAD_RD_FRAME + `DCAD_SRSP_BASE + {4'h0, size_r} -
                          {4'h0, pos_r} - 8'h01;
              end
            end
          end
        end
      end
      ST_TICKS: begin
        cnt_nxt = 12'h000;
        if (ticks_r >= tgt_r) st_nxt = ST_SYNC;
      end
      ST_SYNC: begin
        cnt_nxt = cnt_r + 12'h001;
        if (act_scan_r && cnt_r == 12'(`DCAD_SCAN_CYC - 1)) begin
          scan_nxt = 1'b1;
          st_nxt   = ST_IDLE;
        end else if (!act_scan_r && cnt_r == 12'(`DCAD_RSP_CYC - 1)) begin
          idx_nxt = 6'h00;
          st_nxt  = host_side ? ST_STROBE : ST_LINK;
        end
      end
      ST_STROBE: begin
        dr_n_nxt   = 1'b0;
        rsp_sh_nxt = cur_byte;
        if (cs_low) begin
          miso_nxt   = cur_byte[7];
          rsp_sh_nxt = {cur_byte[6:0], 1'b0};
          st_nxt     = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (sclk_fall) begin
          miso_nxt   = rsp_sh_r[7];
          rsp_sh_nxt = {rsp_sh_r[6:0], 1'b0};
        end
        if (cs_rise) begin
          dr_n_nxt = 1'b1;
          idx_nxt  = idx_r + 6'h01;
          st_nxt   = (idx_r + 6'h01 == len_r) ? ST_IDLE : ST_STROBE;
        end
      end
      ST_LINK: begin
        if (ticks_r >= `DCAD_BYTE_TICKS) begin
          fwd_w_nxt   = '{extra: 4'h0, append: 1'b0, data: cur_byte};
          fwd_tgl_nxt = ~fwd_tgl_r;
          ticks_nxt   = 8'h00;
          pre_nxt     = 12'h000;
          idx_nxt     = idx_r + 6'h01;
          if (idx_r + 6'h01 == len_r) st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
    // Results become readable only after the registers update
    busy_nxt  = meas_update_in ? 1'b0 : (scan_nxt | busy_r);
    ready_nxt = meas_update_in | (ready_r & ~scan_nxt);
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_r       <= ST_IDLE;
      fwd_w_r    <= '0;
      fwd_tgl_r  <= 1'b0;
      spi_sh_r   <= 8'h00;
      spi_bit_r  <= 3'h0;
      spi_byte_r <= 3'h0;
      spi_w_r    <= 32'h0000_0000;
      spi_rw_r   <= 1'b0;
      spi_ev_r   <= 1'b0;
      pos_r      <= 4'h0;
      size_r     <= 4'h0;
      cmd_r      <= 4'h0;
      pre_r      <= 12'h000;
      ticks_r    <= 8'h00;
      cnt_r      <= 12'h000;
      tgt_r      <= 8'h00;
      rsp_sh_r   <= 8'h00;
      len_r      <= 6'h00;
      idx_r      <= 6'h00;
      act_scan_r <= 1'b0;
      pend_r     <= 1'b0;
      scan_r     <= 1'b0;
      busy_r     <= 1'b0;
      ready_r    <= 1'b0;
      dr_n_r     <= 1'b1;
      miso_r     <= 1'b0;
      status_r   <= `DCAD_SETUP_RESET;
    end else begin
      st_r       <= st_nxt;
      fwd_w_r    <= fwd_w_nxt;
      fwd_tgl_r  <= fwd_tgl_nxt;
      spi_sh_r   <= spi_sh_nxt;
      spi_bit_r  <= spi_bit_nxt;
      spi_byte_r <= spi_byte_nxt;
      spi_w_r    <= spi_w_nxt;
      spi_rw_r   <= spi_rw_nxt;
      spi_ev_r   <= spi_ev_nxt;
      pos_r      <= pos_nxt;
      size_r     <= size_nxt;
      cmd_r      <= cmd_nxt;
      pre_r      <= pre_nxt;
      ticks_r    <= ticks_nxt;
      cnt_r      <= cnt_nxt;
      tgt_r      <= tgt_nxt;
      rsp_sh_r   <= rsp_sh_nxt;
      len_r      <= len_nxt;
      idx_r      <= idx_nxt;
      act_scan_r <= act_scan_nxt;
      pend_r     <= pend_nxt;
      scan_r     <= scan_nxt;
      busy_r     <= busy_nxt;
      ready_r    <= ready_nxt;
      dr_n_r     <= dr_n_nxt;
      miso_r     <= miso_nxt;
      status_r   <= status_nxt;
    end
  end

  assign spi_miso_out          = miso_r;
  assign data_ready_n_out      = dr_n_r;
  assign rsp_idx_out           = idx_r;
  assign scan_start_out        = scan_r;
  assign meas_busy_out         = busy_r;
  assign results_ready_out     = ready_r;
  assign link_setup_status_out = status_r;

  // --------------------------------------------------------------------
  // Link domain: receive, relay and transmit
  // --------------------------------------------------------------------
  // The sys side changes fwd_w_r at most once per SPI byte, or once per 9 link periods in ST_LINK, far slower
  // than the three link clocks the toggle needs to cross.
  logic       fs1_r, fs2_r, fs3_r;
  logic [1:0] rl1_r, rl2_r;
  logic [7:0] tx_sh_r, tx_sh_nxt;
  logic [3:0] tx_bits_r, tx_bits_nxt, tx_ex_r, tx_ex_nxt;
  logic       tx_app_r, tx_app_nxt, txd_r, txd_nxt, txf_r, txf_nxt;
  logic [31:0] rx_sh_r, rx_sh_nxt, dz_word_nxt;
  logic [5:0] rx_cnt_r, rx_cnt_nxt;
  logic       rx_rw_r, rx_rw_nxt, dz_len4_nxt, st_tgl_nxt, end_tgl_nxt;

  always_comb begin
    tx_sh_nxt   = tx_sh_r;
    tx_bits_nxt = tx_bits_r;
    tx_ex_nxt   = tx_ex_r;
    tx_app_nxt  = tx_app_r;
    rx_sh_nxt   = rx_sh_r;
    rx_cnt_nxt  = 6'h00;
    rx_rw_nxt   = rx_rw_r;
    dz_word_nxt = dz_word_r;
    dz_len4_nxt = dz_len4_r;
    st_tgl_nxt  = dz_st_tgl_r;
    end_tgl_nxt = dz_end_tgl_r;
    txd_nxt     = 1'b0;
    txf_nxt     = 1'b0;
    if (fs2_r ^ fs3_r) begin
      tx_sh_nxt   = fwd_w_r.data;
      tx_bits_nxt = 4'h8;
      tx_app_nxt  = fwd_w_r.append;
      tx_ex_nxt   = fwd_w_r.extra;
    end else if (tx_bits_r != 4'h0) begin
      txd_nxt     = tx_sh_r[7];
      txf_nxt     = 1'b1;
      tx_sh_nxt   = {tx_sh_r[6:0], 1'b0};
      tx_bits_nxt = tx_bits_r - 4'h1;
      if (tx_bits_r == 4'h1 && tx_app_r) begin
        tx_sh_nxt   = 8'h00;
        tx_bits_nxt = 4'h8;
        tx_app_nxt  = 1'b0;
      end
    end else if (tx_ex_r != 4'h0) begin
      txf_nxt   = 1'b1;
      tx_ex_nxt = tx_ex_r - 4'h1;
    end else if (dcad_role_t'(rl2_r) != ROLE_MASTER) begin
      txd_nxt = daisy_rx_data_in;
      txf_nxt = daisy_rx_frame_in;
    end
    if (daisy_rx_frame_in) begin
      rx_sh_nxt  = {rx_sh_r[30:0], daisy_rx_data_in};
      rx_cnt_nxt = rx_cnt_r + 6'h01;
      if (rx_cnt_r == 6'h00) st_tgl_nxt = ~dz_st_tgl_r;
      if (rx_cnt_r == 6'h04) rx_rw_nxt = daisy_rx_data_in;
      // Last bit of the frame closes it
      if (rx_cnt_r == (rx_rw_nxt ? `DCAD_WR_LAST : `DCAD_RD_LAST)) begin
        dz_word_nxt = rx_sh_nxt;
        dz_len4_nxt = rx_rw_nxt;
        end_tgl_nxt = ~dz_end_tgl_r;
        rx_cnt_nxt  = 6'h00;
      end
    end
  end

  always_ff @(posedge daisy_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fs1_r        <= 1'b0;
      fs2_r        <= 1'b0;
      fs3_r        <= 1'b0;
      rl1_r        <= 2'h0;
      rl2_r        <= 2'h0;
      tx_sh_r      <= 8'h00;
      tx_bits_r    <= 4'h0;
      tx_ex_r      <= 4'h0;
      tx_app_r     <= 1'b0;
      txd_r        <= 1'b0;
      txf_r        <= 1'b0;
      rx_sh_r      <= 32'h0000_0000;
      rx_cnt_r     <= 6'h00;
      rx_rw_r      <= 1'b0;
      dz_word_r    <= 32'h0000_0000;
      dz_len4_r    <= 1'b0;
      dz_st_tgl_r  <= 1'b0;
      dz_end_tgl_r <= 1'b0;
    end else begin
      fs1_r        <= fwd_tgl_r;
      fs2_r        <= fs1_r;
      fs3_r        <= fs2_r;
      rl1_r        <= link_role_strap_in;
      rl2_r        <= rl1_r;
      tx_sh_r      <= tx_sh_nxt;
      tx_bits_r    <= tx_bits_nxt;
      tx_ex_r      <= tx_ex_nxt;
      tx_app_r     <= tx_app_nxt;
      txd_r        <= txd_nxt;
      txf_r        <= txf_nxt;
      rx_sh_r      <= rx_sh_nxt;
      rx_cnt_r     <= rx_cnt_nxt;
      rx_rw_r      <= rx_rw_nxt;
      dz_word_r    <= dz_word_nxt;
      dz_len4_r    <= dz_len4_nxt;
      dz_st_tgl_r  <= st_tgl_nxt;
      dz_end_tgl_r <= end_tgl_nxt;
    end
  end

  assign daisy_tx_data_out  = txd_r;
  assign daisy_tx_frame_out = txf_r;

endmodule
`default_nettype wire

// ===== dv/dcad_props.sv
// Port checks for dcad_top
`timescale 1ns/1ps
`default_nettype none
module dcad_props (
  input wire logic        sys_clk_in,
  input wire logic        reset_n_in,
  input wire logic [1:0]  link_rate_strap_in,
  input wire logic [1:0]  link_role_strap_in,
  input wire logic        meas_update_in,
  input wire logic        scan_start_out,
  input wire logic        meas_busy_out,
  input wire logic        results_ready_out,
  input wire logic [11:0] link_setup_status_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  property p_rate; $stable(link_rate_strap_in)[*4]
    |-> link_setup_status_out[11:10] == link_rate_strap_in; endproperty
  a_rate: assert property (p_rate) else $error("rate field");
  property p_role; $stable(link_role_strap_in)[*4]
    |-> link_setup_status_out[9:8] == link_role_strap_in; endproperty
  a_role: assert property (p_role) else $error("role field");
  property p_pulse; scan_start_out |=> !scan_start_out; endproperty
  a_pulse: assert property (p_pulse) else $error("long pulse");
  property p_busy; scan_start_out |=> meas_busy_out; endproperty
  a_busy: assert property (p_busy) else $error("no busy");
  property p_hold; meas_busy_out && !meas_update_in |=> meas_busy_out;
  endproperty
  a_hold: assert property (p_hold) else $error("busy lost");
  // Busy is raised by the same edge that raises the scan pulse
  property p_idle; $rose(meas_busy_out) |-> scan_start_out; endproperty
  a_idle: assert property (p_idle) else $error("busy no scan");
  property p_done; meas_update_in && !scan_start_out
    |=> !meas_busy_out && results_ready_out; endproperty
  a_done: assert property (p_done) else $error("no done");
  property p_clr; scan_start_out && !meas_update_in |=> !results_ready_out;
  endproperty
  a_clr: assert property (p_clr) else $error("ready kept");
endmodule
bind dcad_top dcad_props u_dcad_props (.sys_clk_in(sys_clk_in),
  .reset_n_in(reset_n_in), .link_rate_strap_in(link_rate_strap_in),
  .link_role_strap_in(link_role_strap_in), .meas_update_in(meas_update_in),
  .scan_start_out(scan_start_out), .meas_busy_out(meas_busy_out),
  .results_ready_out(results_ready_out),
  .link_setup_status_out(link_setup_status_out));
`default_nettype wire

// ===== dv/dcad_link_peer.sv
// Link neighbour below the master: logs relayed bits
`timescale 1ns/1ps
`default_nettype none
module dcad_link_peer (
  input  wire logic   dclk_in,
  input  wire logic   tx_d_in,
  input  wire logic   tx_f_in,
  output logic        rx_d_out,
  output logic        rx_f_out,
  output logic [39:0] bits_out,
  output logic [7:0]  cnt_out
);
  // Idle data toggles so a stale level never reads as data
  initial {rx_d_out, rx_f_out, bits_out, cnt_out} = '0;
  always @(negedge dclk_in) begin
    rx_d_out <= ~rx_d_out;
    if (tx_f_in) begin
      bits_out <= {bits_out[38:0], tx_d_in};
      cnt_out <= cnt_out + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ===== dv/dcad_top_tb.sv
// Bench for dcad_top as chain master
`timescale 1ns/1ps
`default_nettype none
module dcad_top_tb;
  logic clk = 1'b0, dclk = 1'b0, rst_n = 1'b0, sclk = 1'b0, cs_n = 1'b1;
  logic mosi = 1'b0, upd = 1'b0, miso, drdy_n, scan, busy, rdy;
  logic rx_d, rx_f, tx_d, tx_f;
  logic [11:0] st;
  logic [39:0] bits;
  logic [7:0] nb, n0, rb;
  logic [5:0] idx;
  logic [23:0] fr;
  logic [31:0] ex;
  int errors = 0, cmp_count = 0, cyc = 0, seen = 0, w;
  always #2.5 clk = ~clk;
  always #32 dclk = ~dclk;
  dcad_top u_dcad_top (.sys_clk_in(clk), .reset_n_in(rst_n),
    .daisy_clk_in(dclk), .spi_sclk_in(sclk), .spi_cs_n_in(cs_n),
    .spi_mosi_in(mosi), .spi_miso_out(miso), .data_ready_n_out(drdy_n),
    .link_rate_strap_in(2'h0), .link_role_strap_in(2'h1),
    .daisy_rx_data_in(rx_d), .daisy_rx_frame_in(rx_f),
    .daisy_tx_data_out(tx_d), .daisy_tx_frame_out(tx_f),
    .meas_update_in(upd), .rsp_byte_in(8'h00), .rsp_idx_out(idx),
    .scan_start_out(scan), .meas_busy_out(busy),
    .results_ready_out(rdy), .link_setup_status_out(st));
  dcad_link_peer u_dcad_link_peer (.dclk_in(dclk), .tx_d_in(tx_d),
    .tx_f_in(tx_f), .rx_d_out(rx_d), .rx_f_out(rx_f), .bits_out(bits),
    .cnt_out(nb));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic xfer(input logic [7:0] t, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      mosi <= t[i];
      tick(8);
      sclk <= 1'b1;
      r[i] = miso;
      tick(8);
      sclk <= 1'b0;
    end
  endtask
  function automatic logic [3:0] crc(input logic [31:0] v, input int n);
    logic [3:0] c = 4'h0;
    for (int i = 31; i > 31 - n; i--) c = {c[2:1], c[0] ^ c[3], v[i] ^ c[3]};
    return c;
  endfunction
  task automatic cmd(input logic [19:0] h);
    fr = {h, crc({h, 12'h000}, 20)};
    cs_n <= 1'b0;
    tick(8);
    for (int k = 2; k >= 0; k--) xfer(fr[8*k +: 8], rb);
    tick(8);
    cs_n <= 1'b1;
    tick(400);
  endtask
  task automatic final_report();
    if (errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    seen <= seen + int'(scan === 1'b1);
    cyc++;
    if (cyc == 90000) begin
      errors++;
      final_report();
    end
  end
  initial begin
    tick(10);
    rst_n <= 1'b1;
    tick(10);
    chk(st, 12'h100);
    cmd(20'h00013);
    chk(st, 12'h131);
    n0 = nb;
    cmd(20'hf0100);
    chk(seen, 1);
    chk(nb - n0, 8'h21);
    chk(bits[32:1], {fr, 8'h00});
    chk(busy, 1'b1);
    upd <= 1'b1;
    tick(1);
    upd <= 1'b0;
    tick(2);
    chk({busy, rdy}, 2'h1);
    cmd(20'h10300);
    w = 400;
    while (drdy_n === 1'b1 && w < 30000) begin tick(1); w++; end
    chk(w > 20400, 1);
    ex = {24'h100131, 4'h0, crc(32'h10013100, 28)};
    for (int k = 3; k >= 0; k--) begin
      w = 0;
      while (drdy_n !== 1'b0 && w < 100) begin tick(1); w++; end
      cs_n <= 1'b0;
      tick(8);
      xfer(8'h00, rb);
      tick(8);
      cs_n <= 1'b1;
      chk(rb, ex[8*k +: 8]);
      w = 0;
      while (drdy_n !== 1'b1 && w < 8) begin tick(1); w++; end
      chk(w < 8, 1);
    end
    tick(200);
    chk(drdy_n, 1'b1);
    chk(idx, 6'h04);
    final_report();
  end
endmodule
`default_nettype wire
